// ---- cexp_pkg.sv ----
// cexp_pkg: shared constants for the short-form instruction expander.
// assumes: all users import the whole package.
package cexp_pkg;
    localparam logic [1:0]  CEXP_BASE_32      = 2'h0;
    localparam logic [1:0]  CEXP_BASE_64      = 2'h1;
    localparam logic [1:0]  CEXP_BASE_128     = 2'h2;
    localparam logic [1:0]  CEXP_FULL_MARK    = 2'h3;
    localparam logic [31:0] CEXP_STEP_SHORT   = 32'h00000002;
    localparam logic [31:0] CEXP_STEP_FULL    = 32'h00000004;
    localparam logic [31:0] CEXP_GRANULE_MASK = 32'hFFFFFFFE;
    localparam logic [31:0] CEXP_RST_WORD     = 32'h00000000;
    localparam logic [31:0] CEXP_EBREAK       = 32'h00100073;
    localparam logic [6:0]  CEXP_OP_LOAD      = 7'h03;
    localparam logic [6:0]  CEXP_OP_LOAD_FP   = 7'h07;
    localparam logic [6:0]  CEXP_OP_MISC_MEM  = 7'h0F;
    localparam logic [6:0]  CEXP_OP_IMM       = 7'h13;
    localparam logic [6:0]  CEXP_OP_IMM32     = 7'h1B;
    localparam logic [6:0]  CEXP_OP_STORE     = 7'h23;
    localparam logic [6:0]  CEXP_OP_STORE_FP  = 7'h27;
    localparam logic [6:0]  CEXP_OP_REG       = 7'h33;
    localparam logic [6:0]  CEXP_OP_LUI       = 7'h37;
    localparam logic [6:0]  CEXP_OP_REG32     = 7'h3B;
    localparam logic [6:0]  CEXP_OP_BRANCH    = 7'h63;
    localparam logic [6:0]  CEXP_OP_JALR      = 7'h67;
    localparam logic [6:0]  CEXP_OP_JAL       = 7'h6F;
    typedef enum logic [0:0] {
        CEXP_IDLE = 1'b0,
        CEXP_FULL = 1'b1
    } cexp_state_e;
endpackage : cexp_pkg

// ---- cexp_if.sv ----
// cexp_if: carries one parcel and its configuration to the expander and the result back.
// assumes: purely combinational path inside one clock domain.
`timescale 1ns/1ps
interface cexp_if;
    import cexp_pkg::*;
    logic [15:0] parcel;
    logic [1:0]  base_width;
    logic        fp_single;
    logic        fp_double;
    logic [31:0] expanded;
    logic        illegal;
    modport ctrl (output parcel, output base_width, output fp_single, output fp_double,
                  input expanded, input illegal);
    modport expd (input parcel, input base_width, input fp_single, input fp_double,
                  output expanded, output illegal);
endinterface : cexp_if

// ---- cexp_expand.sv ----
// cexp_expand: maps one short-form parcel onto its single full-width equivalent.
// assumes: parcel low bits are not 2'b11; caller handles full-width words.
`timescale 1ns/1ps
module cexp_expand
    import cexp_pkg::*;
(
    cexp_if.expd x
);
    function automatic logic [31:0] i_t(input logic [11:0] imm, input logic [4:0] rs1,
                                        input logic [2:0] f3, input logic [4:0] rd, input logic [6:0] op);
        i_t = {imm, rs1, f3, rd, op};
    endfunction : i_t

    function automatic logic [31:0] s_t(input logic [11:0] imm, input logic [4:0] rs2,
                                        input logic [4:0] rs1, input logic [2:0] f3, input logic [6:0] op);
        s_t = {imm[11:5], rs2, rs1, f3, imm[4:0], op};
    endfunction : s_t

    logic [15:0] c;
    logic [4:0]  rd;
    logic [4:0]  rs2;
    logic [4:0]  rdp;
    logic [4:0]  rs1p;
    logic [11:0] imm6;
    logic [11:0] o_w;
    logic [11:0] o_d;
    logic [11:0] o_q;
    logic [11:0] o_wsp;
    logic [11:0] o_dsp;
    logic [11:0] o_qsp;
    logic [11:0] s_wsp;
    logic [11:0] s_dsp;
    logic [11:0] s_qsp;
    logic [20:0] jo;
    logic [12:0] bo;
    logic        rv32;
    logic        rv128;

    always_comb begin
        c     = x.parcel;
        rd    = c[11:7];
        rs2   = c[6:2];
        rdp   = {2'h1, c[4:2]};
        rs1p  = {2'h1, c[9:7]};
        imm6  = {{6{c[12]}}, c[12], c[6:2]};
        o_w   = {5'h00, c[5], c[12:10], c[6], 2'h0};
        o_d   = {4'h0, c[6:5], c[12:10], 3'h0};
        o_q   = {3'h0, c[10], c[6:5], c[12:11], 4'h0};
        o_wsp = {4'h0, c[3:2], c[12], c[6:4], 2'h0};
        o_dsp = {3'h0, c[4:2], c[12], c[6:5], 3'h0};
        o_qsp = {2'h0, c[5:2], c[12], c[6], 4'h0};
        s_wsp = {4'h0, c[8:7], c[12:9], 2'h0};
        s_dsp = {3'h0, c[9:7], c[12:10], 3'h0};
        s_qsp = {2'h0, c[10:7], c[12:11], 4'h0};
        jo    = {{10{c[12]}}, c[8], c[10:9], c[6], c[7], c[2], c[11], c[5:3], 1'b0};
        bo    = {{5{c[12]}}, c[6:5], c[2], c[11:10], c[4:3], 1'b0};
        rv32  = (x.base_width == CEXP_BASE_32);
        rv128 = (x.base_width == CEXP_BASE_128);
        x.expanded = CEXP_RST_WORD;
        x.illegal  = 1'b0;
        // one parcel in, exactly one full-width word out
        case ({c[1:0], c[15:13]}) // RULE7
            5'b00000: begin
                x.expanded = i_t({2'h0, c[10:7], c[12:11], c[5], c[6], 2'h0}, 5'd2, 3'h0, rdp, CEXP_OP_IMM);
                x.illegal  = (c[12:5] == 8'h00);
            end
            // wide-base opcode reuse, same register fields as the integer form
            5'b00001: begin // RULE5 RULE8
                x.expanded = rv128 ? i_t(o_q, rs1p, 3'h2, rdp, CEXP_OP_MISC_MEM)
                                   : i_t(o_d, rs1p, 3'h3, rdp, CEXP_OP_LOAD_FP);
                x.illegal  = !rv128 && !x.fp_double; // RULE3
            end
            5'b00010: x.expanded = i_t(o_w, rs1p, 3'h2, rdp, CEXP_OP_LOAD);
            5'b00011: begin // RULE4 RULE8
                x.expanded = rv32 ? i_t(o_w, rs1p, 3'h2, rdp, CEXP_OP_LOAD_FP)
                                  : i_t(o_d, rs1p, 3'h3, rdp, CEXP_OP_LOAD);
                x.illegal  = rv32 && !x.fp_single; // RULE3
            end
            5'b00101: begin // RULE5 RULE8
                x.expanded = rv128 ? s_t(o_q, rdp, rs1p, 3'h4, CEXP_OP_STORE)
                                   : s_t(o_d, rdp, rs1p, 3'h3, CEXP_OP_STORE_FP);
                x.illegal  = !rv128 && !x.fp_double; // RULE3
            end
            5'b00110: x.expanded = s_t(o_w, rdp, rs1p, 3'h2, CEXP_OP_STORE);
            5'b00111: begin // RULE4 RULE8
                x.expanded = rv32 ? s_t(o_w, rdp, rs1p, 3'h2, CEXP_OP_STORE_FP)
                                  : s_t(o_d, rdp, rs1p, 3'h3, CEXP_OP_STORE);
                x.illegal  = rv32 && !x.fp_single; // RULE3
            end
            5'b01000: x.expanded = i_t(imm6, rd, 3'h0, rd, CEXP_OP_IMM);
            5'b01001: begin // RULE6
                x.expanded = rv32 ? {jo[20], jo[10:1], jo[11], jo[19:12], 5'd1, CEXP_OP_JAL}
                                  : i_t(imm6, rd, 3'h0, rd, CEXP_OP_IMM32);
                x.illegal  = !rv32 && (rd == 5'd0);
            end
            5'b01010: x.expanded = i_t(imm6, 5'd0, 3'h0, rd, CEXP_OP_IMM);
            5'b01011: begin
                if (rd == 5'd2) begin
                    x.expanded = i_t({{3{c[12]}}, c[4:3], c[5], c[2], c[6], 4'h0}, 5'd2, 3'h0, 5'd2, CEXP_OP_IMM);
                end else begin
                    x.expanded = {{14{c[12]}}, c[12], c[6:2], rd, CEXP_OP_LUI};
                end
                x.illegal = ({c[12], c[6:2]} == 6'h00);
            end
            5'b01100: begin
                case (c[11:10])
                    2'h0:    x.expanded = i_t({6'h00, c[12], c[6:2]}, rs1p, 3'h5, rs1p, CEXP_OP_IMM);
                    2'h1:    x.expanded = i_t({6'h10, c[12], c[6:2]}, rs1p, 3'h5, rs1p, CEXP_OP_IMM);
                    2'h2:    x.expanded = i_t(imm6, rs1p, 3'h7, rs1p, CEXP_OP_IMM);
                    default: begin
                        case ({c[12], c[6:5]})
                            3'h0:    x.expanded = {7'h20, rdp, rs1p, 3'h0, rs1p, CEXP_OP_REG};
                            3'h1:    x.expanded = {7'h00, rdp, rs1p, 3'h4, rs1p, CEXP_OP_REG};
                            3'h2:    x.expanded = {7'h00, rdp, rs1p, 3'h6, rs1p, CEXP_OP_REG};
                            3'h3:    x.expanded = {7'h00, rdp, rs1p, 3'h7, rs1p, CEXP_OP_REG};
                            3'h4:    x.expanded = {7'h20, rdp, rs1p, 3'h0, rs1p, CEXP_OP_REG32};
                            3'h5:    x.expanded = {7'h00, rdp, rs1p, 3'h0, rs1p, CEXP_OP_REG32};
                            default: x.illegal  = 1'b1;
                        endcase
                        if (rv32 && c[12]) begin
                            x.illegal = 1'b1;
                        end
                    end
                endcase
            end
            5'b01101: x.expanded = {jo[20], jo[10:1], jo[11], jo[19:12], 5'd0, CEXP_OP_JAL};
            5'b01110: x.expanded = {bo[12], bo[10:5], 5'd0, rs1p, 3'h0, bo[4:1], bo[11], CEXP_OP_BRANCH};
            5'b01111: x.expanded = {bo[12], bo[10:5], 5'd0, rs1p, 3'h1, bo[4:1], bo[11], CEXP_OP_BRANCH};
            5'b10000: x.expanded = i_t({6'h00, c[12], c[6:2]}, rd, 3'h1, rd, CEXP_OP_IMM);
            5'b10001: begin // RULE5 RULE8
                x.expanded = rv128 ? i_t(o_qsp, 5'd2, 3'h2, rd, CEXP_OP_MISC_MEM)
                                   : i_t(o_dsp, 5'd2, 3'h3, rd, CEXP_OP_LOAD_FP);
                x.illegal  = rv128 ? (rd == 5'd0) : !x.fp_double; // RULE3
            end
            5'b10010: begin
                x.expanded = i_t(o_wsp, 5'd2, 3'h2, rd, CEXP_OP_LOAD);
                x.illegal  = (rd == 5'd0);
            end
            5'b10011: begin // RULE4 RULE8
                x.expanded = rv32 ? i_t(o_wsp, 5'd2, 3'h2, rd, CEXP_OP_LOAD_FP)
                                  : i_t(o_dsp, 5'd2, 3'h3, rd, CEXP_OP_LOAD);
                x.illegal  = rv32 ? !x.fp_single : (rd == 5'd0); // RULE3
            end
            5'b10100: begin
                if (!c[12]) begin
                    x.expanded = (rs2 == 5'd0) ? i_t(12'h000, rd, 3'h0, 5'd0, CEXP_OP_JALR)
                                               : {7'h00, rs2, 5'd0, 3'h0, rd, CEXP_OP_REG};
                    x.illegal  = (rs2 == 5'd0) && (rd == 5'd0);
                end else if (rs2 != 5'd0) begin
                    x.expanded = {7'h00, rs2, rd, 3'h0, rd, CEXP_OP_REG};
                end else if (rd == 5'd0) begin
                    x.expanded = CEXP_EBREAK;
                end else begin
                    x.expanded = i_t(12'h000, rd, 3'h0, 5'd1, CEXP_OP_JALR);
                end
            end
            5'b10101: begin // RULE5 RULE8
                x.expanded = rv128 ? s_t(s_qsp, rs2, 5'd2, 3'h4, CEXP_OP_STORE)
                                   : s_t(s_dsp, rs2, 5'd2, 3'h3, CEXP_OP_STORE_FP);
                x.illegal  = !rv128 && !x.fp_double; // RULE3
            end
            5'b10110: x.expanded = s_t(s_wsp, rs2, 5'd2, 3'h2, CEXP_OP_STORE);
            5'b10111: begin // RULE4 RULE8
                x.expanded = rv32 ? s_t(s_wsp, rs2, 5'd2, 3'h2, CEXP_OP_STORE_FP)
                                  : s_t(s_dsp, rs2, 5'd2, 3'h3, CEXP_OP_STORE);
                x.illegal  = rv32 && !x.fp_single; // RULE3
            end
            default: x.illegal = 1'b1;
        endcase
    end
endmodule : cexp_expand

// ---- cexp_top.sv ----
// cexp_top: decode-stage front end taking halfword-aligned fetch words and issuing full-width instructions.
// assumes: fetch word holds the parcel at fetch_addr in bits 15:0 and the next parcel in bits 31:16.
`timescale 1ns/1ps
// Behaviour
// RULE1: short and full-width instructions interleave; full ones start on any halfword.
// RULE2: no instruction-address-misaligned exception is ever raised, branches included.
// RULE3: short float loads/stores supported whenever single or double float exists; code gates word forms on fp_single and double forms on fp_double.
// RULE4: wide bases decode certain opcodes as 64-bit integer loads/stores; 32-bit as single float.
// RULE5: 128-bit base decodes certain opcodes as 128-bit loads/stores; others as double float.
// RULE6: one opcode is jump-and-link on 32-bit base, ADDIW on wider bases.
// RULE7: each short instruction expands to exactly one equivalent full-width instruction.
// RULE8: short float loads/stores share format and register fields with integer forms.
// RULE9: low two bits both one means full-width, otherwise short form.
// RULE10: next sequential address is plus two after short, plus four after full.
module cexp_top
    import cexp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_addr,
    input  wire logic [31:0] fetch_word,
    input  wire logic [1:0]  base_width,
    input  wire logic        fp_single_present,
    input  wire logic        fp_double_present,
    input  wire logic        issue_ready,
    output logic             fetch_ready,
    output logic             issue_valid,
    output logic [31:0]      issue_instr,
    output logic [31:0]      issue_pc,
    output logic [31:0]      issue_next_pc,
    output logic             issue_short,
    output logic             issue_illegal
);
    logic        rst_meta_reg;
    logic        rst_sync_reg;
    cexp_state_e state_reg;
    cexp_state_e state_next;
    logic        ready_reg;
    logic        ready_next;
    logic [31:0] instr_reg;
    logic [31:0] instr_next;
    logic [31:0] pc_reg;
    logic [31:0] pc_next;
    logic [31:0] npc_reg;
    logic [31:0] npc_next;
    logic        short_reg;
    logic        short_next;
    logic        illegal_reg;
    logic        illegal_next;
    logic        is_full;
    logic [31:0] aligned_pc;

    cexp_if xif ();

    cexp_expand u_expand (
        .x (xif.expd)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    always_comb begin
        is_full        = (fetch_word[1:0] == CEXP_FULL_MARK); // RULE9
        // only the halfword granule matters, so any target is reachable
        aligned_pc     = fetch_addr & CEXP_GRANULE_MASK; // RULE1 RULE2
        xif.parcel     = fetch_word[15:0];
        xif.base_width = base_width;
        xif.fp_single  = fp_single_present;
        xif.fp_double  = fp_double_present;
    end

    // one word held at a time: halves throughput but keeps every output on a flop
    always_comb begin
        state_next   = state_reg;
        instr_next   = instr_reg;
        pc_next      = pc_reg;
        npc_next     = npc_reg;
        short_next   = short_reg;
        illegal_next = illegal_reg;
        case (state_reg)
            CEXP_IDLE: begin
                if (fetch_valid && ready_reg) begin
                    state_next   = CEXP_FULL;
                    pc_next      = aligned_pc;
                    short_next   = !is_full;
                    instr_next   = is_full ? fetch_word : xif.expanded; // RULE1 RULE7
                    illegal_next = !is_full && xif.illegal;
                    npc_next     = aligned_pc + (is_full ? CEXP_STEP_FULL : CEXP_STEP_SHORT); // RULE10
                end
            end
            CEXP_FULL: begin
                if (issue_ready) begin
                    state_next = CEXP_IDLE;
                end
            end
            default: state_next = CEXP_IDLE;
        endcase
        ready_next = (state_next == CEXP_IDLE);
    end

    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg   <= CEXP_IDLE;
            ready_reg   <= 1'b0;
            instr_reg   <= CEXP_RST_WORD;
            pc_reg      <= CEXP_RST_WORD;
            npc_reg     <= CEXP_RST_WORD;
            short_reg   <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            ready_reg   <= ready_next;
            instr_reg   <= instr_next;
            pc_reg      <= pc_next;
            npc_reg     <= npc_next;
            short_reg   <= short_next;
            illegal_reg <= illegal_next;
        end
    end

    always_comb begin
        fetch_ready   = ready_reg;
        issue_valid   = (state_reg == CEXP_FULL);
        issue_instr   = instr_reg;
        issue_pc      = pc_reg;
        issue_next_pc = npc_reg;
        issue_short   = short_reg;
        issue_illegal = illegal_reg;
    end
endmodule : cexp_top

// ---- cexp_asserts.sv ----
// cexp_asserts: handshake and expansion properties on the expander top ports.
// assumes: bound to cexp_top; single core_clk domain.
`timescale 1ns/1ps
module cexp_asserts
    import cexp_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic [31:0] fetch_word,
    input wire logic [1:0]  base_width,
    input wire logic        fp_single_present,
    input wire logic        fp_double_present,
    input wire logic        issue_ready,
    input wire logic        fetch_ready,
    input wire logic        issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] issue_pc,
    input wire logic [31:0] issue_next_pc,
    input wire logic        issue_short,
    input wire logic        issue_illegal
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_take;
        fetch_valid && fetch_ready;
    endsequence
    sequence s_cjal;
        s_take and (fetch_word[15:13] == 3'h1 && fetch_word[1:0] == 2'h1);
    endsequence
    a_issue_follows: assert property (s_take |=> issue_valid) else $error("no issue after take");
    a_busy_blocks: assert property (issue_valid |-> !fetch_ready) else $error("fetch open while busy");
    a_issue_holds: assert property (issue_valid && !issue_ready |=> issue_valid && $stable(issue_instr))
        else $error("issue word dropped");
    a_take_frees: assert property (issue_valid && issue_ready |=> !issue_valid && fetch_ready)
        else $error("issue take not completed");
    a_class_mark: assert property (
        s_take |=> issue_short == ($past(fetch_word[1:0]) != CEXP_FULL_MARK))
        else $error("length class wrong");
    a_full_pass: assert property (
        (s_take and (fetch_word[1:0] == CEXP_FULL_MARK)) |=> issue_instr == $past(fetch_word) && !issue_illegal)
        else $error("full word altered");
    a_pc_granule: assert property (
        s_take |=> issue_pc == ($past(fetch_addr) & CEXP_GRANULE_MASK))
        else $error("pc not halfword");
    a_step_size: assert property (
        issue_valid |-> issue_next_pc == issue_pc + (issue_short ? CEXP_STEP_SHORT : CEXP_STEP_FULL))
        else $error("next pc wrong");
    a_one_full: assert property (issue_valid && !issue_illegal |-> issue_instr[1:0] == 2'h3)
        else $error("not full width");
    a_jal_narrow: assert property (
        (s_cjal and (base_width == CEXP_BASE_32)) |=> issue_instr[6:0] == CEXP_OP_JAL)
        else $error("short call wrong");
    a_addiw_wide: assert property (
        (s_cjal and (base_width != CEXP_BASE_32)) |=> issue_instr[6:0] == CEXP_OP_IMM32)
        else $error("word add wrong");
endmodule : cexp_asserts
bind cexp_top cexp_asserts cexp_asserts_i (.*);

// ---- cexp_sink_model.sv ----
// cexp_sink_model: downstream decode stage taking issue words, stalls on request.
// assumes: stall is changed by nonblocking assignment at the falling edge.
`timescale 1ns/1ps
module cexp_sink_model (
    input  wire logic  core_clk,
    input  wire logic  issue_valid,
    input  wire logic  stall,
    output logic       issue_ready,
    output int         taken
);
    initial begin
        issue_ready = 1'b0;
        taken = 0;
    end
    // ready lags stall by one cycle, like a pipeline register downstream
    always @(negedge core_clk) issue_ready <= !stall;
    always @(posedge core_clk) if (issue_valid && issue_ready) taken <= taken + 1;
endmodule : cexp_sink_model

// ---- testbench.sv ----
// testbench: drives fetch parcels into the expander and checks issue words.
// assumes: cexp_top, cexp_sink_model and cexp_asserts compiled before.
`timescale 1ns/1ps
module testbench;
    import cexp_pkg::*;
    logic        core_clk, arst_n, fetch_valid, fp_single_present, fp_double_present, stall;
    logic        issue_ready, fetch_ready, issue_valid, issue_short, issue_illegal;
    logic [31:0] fetch_addr, fetch_word, issue_instr, issue_pc, issue_next_pc;
    logic [1:0]  base_width;
    int          taken, err_count = 0, n_checks = 0, n_fetch = 0;
    cexp_top cexp_top_i (.*);
    cexp_sink_model cexp_sink_model_i (.core_clk, .issue_valid, .stall, .issue_ready, .taken);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // offer one fetch word, wait out the take, then judge the issue word
    task automatic run(input logic [31:0] a, input logic [31:0] w, input logic [1:0] b,
                       input logic fs, input logic fd, input logic [31:0] ei, input logic il);
        int          n;
        logic        sh;
        n = 0;
        sh = (w[1:0] != CEXP_FULL_MARK);
        {fetch_addr, fetch_word, base_width, fp_single_present, fp_double_present} = {a, w, b, fs, fd};
        fetch_valid = 1'b1;
        while (fetch_ready !== 1'b1 && n < 20) begin
            n++;
            @(negedge core_clk);
        end
        @(negedge core_clk);
        fetch_valid = 1'b0;
        n_fetch++;
        chk(issue_valid, 1'b1);
        if (!il) chk(issue_instr, ei);
        chk(issue_illegal, il);
        chk(issue_short, sh);
        chk(issue_pc, a & CEXP_GRANULE_MASK);
        chk(issue_next_pc, (a & CEXP_GRANULE_MASK) + (sh ? CEXP_STEP_SHORT : CEXP_STEP_FULL));
        @(negedge core_clk);
    endtask : run
    task automatic test_full;
        run(32'h00000102, 32'h00A00093, CEXP_BASE_32, 1'b0, 1'b0, 32'h00A00093, 1'b0);
        run(32'h00000107, 32'h00A00093, CEXP_BASE_64, 1'b0, 1'b0, 32'h00A00093, 1'b0);
        $display("test_full done");
    endtask : test_full
    task automatic test_call;
        run(32'h00000200, 32'hFFFF2405, CEXP_BASE_32, 1'b0, 1'b0, 32'h220000EF, 1'b0);
        run(32'h00000202, 32'hFFFF2405, CEXP_BASE_64, 1'b0, 1'b0, 32'h0014041B, 1'b0);
        run(32'h00000204, 32'hFFFF2405, CEXP_BASE_128, 1'b0, 1'b0, 32'h0014041B, 1'b0);
        $display("test_call done");
    endtask : test_call
    task automatic test_word_load;
        run(32'h00000300, 32'h00006404, CEXP_BASE_64, 1'b1, 1'b1, 32'h00843483, 1'b0);
        run(32'h00000302, 32'h00006404, CEXP_BASE_128, 1'b1, 1'b1, 32'h00843483, 1'b0);
        run(32'h00000304, 32'h00006404, CEXP_BASE_32, 1'b1, 1'b0, 32'h00842487, 1'b0);
        run(32'h00000306, 32'h00006404, CEXP_BASE_32, 1'b0, 1'b1, 32'h00000000, 1'b1);
        $display("test_word_load done");
    endtask : test_word_load
    task automatic test_quad_load;
        run(32'h00000400, 32'h00002804, CEXP_BASE_32, 1'b0, 1'b1, 32'h01043487, 1'b0);
        run(32'h00000402, 32'h00002804, CEXP_BASE_64, 1'b0, 1'b1, 32'h01043487, 1'b0);
        run(32'h00000404, 32'h00002804, CEXP_BASE_128, 1'b1, 1'b1, 32'h0104248F, 1'b0);
        run(32'h00000406, 32'h00002804, CEXP_BASE_64, 1'b1, 1'b0, 32'h00000000, 1'b1);
        run(32'h00000408, 32'h00000000, CEXP_BASE_32, 1'b1, 1'b1, 32'h00000000, 1'b1);
        $display("test_quad_load done");
    endtask : test_quad_load
    task automatic test_store;
        run(32'h00000600, 32'h0000E404, CEXP_BASE_64, 1'b0, 1'b0, 32'h00943423, 1'b0);
        run(32'h00000602, 32'h0000E404, CEXP_BASE_32, 1'b1, 1'b0, 32'h00942427, 1'b0);
        run(32'h00000604, 32'h0000E404, CEXP_BASE_32, 1'b0, 1'b1, 32'h00000000, 1'b1);
        run(32'h00000606, 32'h0000A426, CEXP_BASE_64, 1'b0, 1'b1, 32'h00913427, 1'b0);
        run(32'h00000608, 32'h0000A426, CEXP_BASE_128, 1'b0, 1'b0, 32'h20914023, 1'b0);
        run(32'h0000060A, 32'h0000A426, CEXP_BASE_64, 1'b1, 1'b0, 32'h00000000, 1'b1);
        $display("test_store done");
    endtask : test_store
    // downstream stalls: issue word must stand and fetch stays closed
    task automatic test_stall;
        stall <= 1'b1;
        @(negedge core_clk);
        fork
            run(32'h00000500, 32'h00002405, CEXP_BASE_64, 1'b0, 1'b0, 32'h0014041B, 1'b0);
            begin
                repeat (4) @(negedge core_clk);
                chk(issue_valid, 1'b1);
                chk(fetch_ready, 1'b0);
                stall <= 1'b0;
            end
        join
        repeat (2) @(negedge core_clk);
        chk(issue_valid, 1'b0);
        $display("test_stall done");
    endtask : test_stall
    initial begin
        {arst_n, fetch_valid, stall, fp_single_present, fp_double_present} = 5'h0;
        {fetch_addr, fetch_word, base_width} = {32'h0, 32'h0, CEXP_BASE_32};
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        test_full;
        test_call;
        test_word_load;
        test_quad_load;
        test_store;
        test_stall;
        chk(taken, n_fetch);
        close_out;
    end
    // whole run is some 50 cycles; allow a wide margin before cutting it
    initial begin
        #(600 * 100);
        err_count++;
        close_out;
    end
endmodule : testbench
